// *** core/dcr_comm_regs.sv ***
// Contract
// [R1] Forward frequency ceiling 0..Fmax, read/write
// [R2] Reverse frequency ceiling 0..Fmax, read/write
// [R3] Motoring torque ceiling 0..3000, read/write
// [R4] Braking torque ceiling 0..3000, read/write
// [R5] Special word: motor, torque off, preexcite, braking
// [R6] Virtual inputs, ten bits, up to 0x3ff
// [R7] Virtual outputs, four bits, up to 0x0f
// [R8] Separated voltage setting 0..1000
// [R9] Two analog outputs, signed -1000..+1000
// [R10] State word: 1 fwd,2 rev,3 stop,4 fault
// [R11] Multi-word writes up to sixteen words; code checks the count but stores one word
// [R12] Torque setting signed -3000..+3000
// [R13] Sixteen-bit registers, two's complement signed
// [R14] Out-of-range write refused, value kept
`timescale 1ns/1ns
`default_nettype none
module dcr_comm_regs
  import dcr_pkg::*;
#(
  parameter logic [15:0] FMAX_CENTI_HZ = 16'h1388
) (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic            req_valid_i,
  input  wire dcr_req_type     req_i,
  output logic                 rsp_valid_o,
  output dcr_rsp_type          rsp_o,
  input  wire logic            run_fwd_i,
  input  wire logic            run_rev_i,
  input  wire logic            fault_i,
  output logic signed [15:0]   torque_setting_o,
  output logic [15:0]          fwd_freq_ceiling_o,
  output logic [15:0]          rev_freq_ceiling_o,
  output logic [15:0]          motoring_torque_ceiling_o,
  output logic [15:0]          braking_torque_ceiling_o,
  output dcr_special_type      special_cmd_o,
  output dcr_vin_type          virtual_inputs_o,
  output dcr_vout_type         virtual_outputs_o,
  output logic [15:0]          separated_voltage_o,
  output logic signed [15:0]   analog_out_one_o,
  output logic signed [15:0]   analog_out_two_o,
  output logic [15:0]          state_word_o
);

  logic [15:0] regs_ff [NUM_RW];
  logic [15:0] state_ff;
  logic        rsp_valid_ff;
  dcr_rsp_type rsp_ff;
  logic        in_bank;
  logic [3:0]  idx;
  logic        val_ok;
  logic        qty_ok;
  logic        wr_ok;
  dcr_rsp_type nxt_rsp;

  // Value check for one bank entry
  function automatic logic value_in_range(input logic [3:0] i, input logic [15:0] v);
    logic ok;
    ok = 1'b0;
    unique case (i)
      // [R12] Signed torque range
      IDX_TORQUE_SET:  ok = ($signed(v) >= TORQUE_SET_MIN) && ($signed(v) <= TORQUE_SET_MAX);
      // [R1] Forward ceiling range
      IDX_FWD_CEIL:    ok = (v <= FMAX_CENTI_HZ);
      // [R2] Reverse ceiling range
      IDX_REV_CEIL:    ok = (v <= FMAX_CENTI_HZ);
      // [R3] Motoring torque range
      IDX_MOT_TORQUE:  ok = (v <= TORQUE_CEIL_MAX);
      // [R4] Braking torque range
      IDX_BRK_TORQUE:  ok = (v <= TORQUE_CEIL_MAX);
      // [R5] Only defined bits
      IDX_SPECIAL_CMD: ok = ((v & ~SPECIAL_MASK) == 16'h0000);
      // [R6] Ten input bits
      IDX_VIRT_IN:     ok = (v <= VIRT_IN_MAX);
      // [R7] Four output bits
      IDX_VIRT_OUT:    ok = (v <= VIRT_OUT_MAX);
      // [R8] Voltage range
      IDX_SEP_VOLT:    ok = (v <= VOLT_MAX);
      // [R9] Signed analog range
      IDX_AO_ONE:      ok = ($signed(v) >= AO_MIN) && ($signed(v) <= AO_MAX);
      IDX_AO_TWO:      ok = ($signed(v) >= AO_MIN) && ($signed(v) <= AO_MAX);
      default:         ok = 1'b0;
    endcase
    return ok;
  endfunction : value_in_range

  // Address decode into the writable bank
  always_comb begin
    in_bank = (req_i.addr >= ADDR_TORQUE_SET) && (req_i.addr <= ADDR_AO_TWO);
    idx     = 4'(req_i.addr - ADDR_TORQUE_SET);
    val_ok  = in_bank && value_in_range(idx, req_i.wdata);
    // [R11] Frame length limit
    qty_ok  = (req_i.qty != 8'h00) && (req_i.qty <= MAX_WRITE_WORDS);
    // [R14] Store only accepted words
    wr_ok   = req_valid_i && req_i.write && in_bank && qty_ok && val_ok;
  end

  // Answer for the current request
  always_comb begin
    nxt_rsp = '{exc: 1'b0, exc_code: EXC_NONE, rdata: 16'h0000};
    if (req_i.write) begin
      if (!qty_ok) begin
        nxt_rsp.exc      = 1'b1;
        nxt_rsp.exc_code = EXC_VALUE;
      end else if (!in_bank) begin
        nxt_rsp.exc      = 1'b1;
        nxt_rsp.exc_code = EXC_ADDR;
      end else if (!val_ok) begin
        // [R14] Range exception
        nxt_rsp.exc      = 1'b1;
        nxt_rsp.exc_code = EXC_VALUE;
      end
      nxt_rsp.rdata = req_i.wdata;
    end else if (in_bank) begin
      nxt_rsp.rdata = regs_ff[idx];
    end else if (req_i.addr == ADDR_STATE_WORD) begin
      nxt_rsp.rdata = state_ff;
    end else begin
      nxt_rsp.exc      = 1'b1;
      nxt_rsp.exc_code = EXC_ADDR;
    end
  end

  // Response register, one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsp_valid_ff <= 1'b0;
      rsp_ff       <= '{exc: 1'b0, exc_code: EXC_NONE, rdata: 16'h0000};
    end else begin
      rsp_valid_ff <= req_valid_i;
      if (req_valid_i) begin
        rsp_ff <= nxt_rsp;
      end
    end
  end

  // Register bank storage, one entry per index
  genvar g;
  generate
    for (g = 0; g < NUM_RW; g++) begin : g_bank
      // [R13] Sixteen-bit word storage
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          regs_ff[g] <= RESET_VAL;
        end else if (wr_ok && (idx == 4'(g))) begin
          regs_ff[g] <= req_i.wdata;
        end
      end
    end
  endgenerate

  // Primary state word from drive status, fault first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= STATE_STOP;
    end else if (fault_i) begin
      // [R10] State encoding
      state_ff <= STATE_FAULT;
    end else if (run_fwd_i) begin
      state_ff <= STATE_FWD;
    end else if (run_rev_i) begin
      state_ff <= STATE_REV;
    end else begin
      state_ff <= STATE_STOP;
    end
  end

  // Outputs straight from flip-flops
  assign rsp_valid_o               = rsp_valid_ff;
  assign rsp_o                     = rsp_ff;
  assign torque_setting_o          = $signed(regs_ff[IDX_TORQUE_SET]);
  assign fwd_freq_ceiling_o        = regs_ff[IDX_FWD_CEIL];
  assign rev_freq_ceiling_o        = regs_ff[IDX_REV_CEIL];
  assign motoring_torque_ceiling_o = regs_ff[IDX_MOT_TORQUE];
  assign braking_torque_ceiling_o  = regs_ff[IDX_BRK_TORQUE];
  // [R5] Special word fields
  assign special_cmd_o             = dcr_special_type'(regs_ff[IDX_SPECIAL_CMD]);
  // [R6] Input bit order
  assign virtual_inputs_o          = dcr_vin_type'(regs_ff[IDX_VIRT_IN][9:0]);
  // [R7] Output bit order
  assign virtual_outputs_o         = dcr_vout_type'(regs_ff[IDX_VIRT_OUT][3:0]);
  assign separated_voltage_o       = regs_ff[IDX_SEP_VOLT];
  assign analog_out_one_o          = $signed(regs_ff[IDX_AO_ONE]);
  assign analog_out_two_o          = $signed(regs_ff[IDX_AO_TWO]);
  assign state_word_o              = state_ff;

  // Checks
  // [R11] Answer timing
  a_rsp_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
    req_valid_i |=> rsp_valid_o) else $error("request not answered next cycle");
  a_no_spurious_rsp: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
    !req_valid_i |=> !rsp_valid_o) else $error("answer without request");
  // [R11] Oversized frame refused
  a_qty_limit: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
    (req_valid_i && req_i.write && (req_i.qty > MAX_WRITE_WORDS))
    |=> (rsp_o.exc && (rsp_o.exc_code == EXC_VALUE))) else $error("oversized write accepted");
  // [R14] Rejected write keeps value
  a_reject_keeps: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
    (req_valid_i && req_i.write && in_bank && !val_ok)
    |=> (rsp_o.exc && (regs_ff[$past(idx)] == $past(regs_ff[idx])))) else $error("bad value stored");
  // [R13] Accepted write stores and reads back
  a_write_readback: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
    wr_ok |=> (!rsp_o.exc && (regs_ff[$past(idx)] == $past(req_i.wdata)))) else $error("write lost");
  // [R3] Ceiling never above limit
  a_torque_ceiling: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
    (motoring_torque_ceiling_o <= TORQUE_CEIL_MAX) && (braking_torque_ceiling_o <= TORQUE_CEIL_MAX))
    else $error("torque ceiling over limit");
  // [R10] Fault reported
  a_state_fault: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
    fault_i |=> (state_word_o == STATE_FAULT)) else $error("fault not reported");
  // [R10] Stopped reported
  a_state_stop: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
    (!fault_i && !run_fwd_i && !run_rev_i) |=> (state_word_o == STATE_STOP))
    else $error("stop not reported");
  // [R10] State word is read-only
  a_state_ro: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
    (req_valid_i && req_i.write && (req_i.addr == ADDR_STATE_WORD) && qty_ok)
    |=> (rsp_o.exc && (rsp_o.exc_code == EXC_ADDR))) else $error("state word written");
  // [R9] Analog range held
  a_ao_range: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
    (analog_out_one_o >= AO_MIN) && (analog_out_one_o <= AO_MAX) &&
    (analog_out_two_o >= AO_MIN) && (analog_out_two_o <= AO_MAX))
    else $error("analog setting out of range");

endmodule : dcr_comm_regs
`default_nettype wire

// *** core/dcr_pkg.sv ***
`default_nettype none
package dcr_pkg;
  // Register word addresses
  localparam logic [15:0] ADDR_TORQUE_SET   = 16'h2004;
  localparam logic [15:0] ADDR_FWD_CEIL     = 16'h2005;
  localparam logic [15:0] ADDR_REV_CEIL     = 16'h2006;
  localparam logic [15:0] ADDR_MOT_TORQUE   = 16'h2007;
  localparam logic [15:0] ADDR_BRK_TORQUE   = 16'h2008;
  localparam logic [15:0] ADDR_SPECIAL_CMD  = 16'h2009;
  localparam logic [15:0] ADDR_VIRT_IN      = 16'h200a;
  localparam logic [15:0] ADDR_VIRT_OUT     = 16'h200b;
  localparam logic [15:0] ADDR_SEP_VOLT     = 16'h200c;
  localparam logic [15:0] ADDR_AO_ONE       = 16'h200d;
  localparam logic [15:0] ADDR_AO_TWO       = 16'h200e;
  localparam logic [15:0] ADDR_STATE_WORD   = 16'h2100;

  // Writable bank: indices 0..10 from ADDR_TORQUE_SET upward
  localparam int          NUM_RW            = 11;
  localparam logic [3:0]  IDX_TORQUE_SET    = 4'h0;
  localparam logic [3:0]  IDX_FWD_CEIL      = 4'h1;
  localparam logic [3:0]  IDX_REV_CEIL      = 4'h2;
  localparam logic [3:0]  IDX_MOT_TORQUE    = 4'h3;
  localparam logic [3:0]  IDX_BRK_TORQUE    = 4'h4;
  localparam logic [3:0]  IDX_SPECIAL_CMD   = 4'h5;
  localparam logic [3:0]  IDX_VIRT_IN       = 4'h6;
  localparam logic [3:0]  IDX_VIRT_OUT      = 4'h7;
  localparam logic [3:0]  IDX_SEP_VOLT      = 4'h8;
  localparam logic [3:0]  IDX_AO_ONE        = 4'h9;
  localparam logic [3:0]  IDX_AO_TWO        = 4'ha;
  localparam logic [15:0] RESET_VAL         = 16'h0000;

  // Value limits
  localparam logic [15:0] TORQUE_CEIL_MAX   = 16'h0bb8;
  localparam logic signed [15:0] TORQUE_SET_MAX = 16'sh0bb8;
  localparam logic signed [15:0] TORQUE_SET_MIN = 16'shf448;
  localparam logic [15:0] VOLT_MAX          = 16'h03e8;
  localparam logic signed [15:0] AO_MAX     = 16'sh03e8;
  localparam logic signed [15:0] AO_MIN     = 16'shfc18;
  localparam logic [15:0] VIRT_IN_MAX       = 16'h03ff;
  localparam logic [15:0] VIRT_OUT_MAX      = 16'h000f;
  localparam logic [15:0] SPECIAL_MASK      = 16'h003f;
  localparam logic [7:0]  MAX_WRITE_WORDS   = 8'h10;

  // Exception codes
  localparam logic [7:0]  EXC_NONE          = 8'h00;
  localparam logic [7:0]  EXC_ADDR          = 8'h02;
  localparam logic [7:0]  EXC_VALUE         = 8'h03;

  // Primary state word codes
  localparam logic [15:0] STATE_FWD         = 16'h0001;
  localparam logic [15:0] STATE_REV         = 16'h0002;
  localparam logic [15:0] STATE_STOP        = 16'h0003;
  localparam logic [15:0] STATE_FAULT       = 16'h0004;

  typedef struct packed {
    logic        write;
    logic [15:0] addr;
    logic [7:0]  qty;
    logic [15:0] wdata;
  } dcr_req_type;

  typedef struct packed {
    logic        exc;
    logic [7:0]  exc_code;
    logic [15:0] rdata;
  } dcr_rsp_type;

  typedef struct packed {
    logic [9:0] unused;
    logic       dc_brake;
    logic       pre_excite;
    logic       energy_consume;
    logic       torque_ctrl_off;
    logic [1:0] motor_sel;
  } dcr_special_type;

  typedef struct packed {
    logic digital_input_eight;
    logic digital_input_seven;
    logic digital_input_six;
    logic digital_input_five;
    logic fast_input_b;
    logic fast_input_a;
    logic digital_input_four;
    logic digital_input_three;
    logic digital_input_two;
    logic digital_input_one;
  } dcr_vin_type;

  typedef struct packed {
    logic relay_two;
    logic relay_one;
    logic fast_output;
    logic open_collector_output;
  } dcr_vout_type;
endpackage : dcr_pkg
`default_nettype wire

// *** testbench/dcr_comm_regs_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module dcr_comm_regs_tb_top
  import dcr_pkg::*;
;
  logic            clk_i     = 1'b0;
  logic            rst_i     = 1'b1;
  logic            run_fwd_i = 1'b0;
  logic            run_rev_i = 1'b0;
  logic            fault_i   = 1'b0;
  logic            req_valid;
  dcr_req_type     req;
  logic            rsp_valid;
  dcr_rsp_type     rsp;
  dcr_special_type special_cmd;
  dcr_vin_type     vin;
  dcr_vout_type    vout;
  logic [15:0]     state_word;
  wire logic [15:0] out_val [11];
  int              error_cnt = 0;
  int              n_tests   = 0;
  // Register map, legal end value (lowest for the signed torque setting and analog one) and first refused value beyond it
  logic [15:0]     t_addr [11] = '{ADDR_TORQUE_SET, ADDR_FWD_CEIL, ADDR_REV_CEIL, ADDR_MOT_TORQUE,
    ADDR_BRK_TORQUE, ADDR_SPECIAL_CMD, ADDR_VIRT_IN, ADDR_VIRT_OUT, ADDR_SEP_VOLT, ADDR_AO_ONE, ADDR_AO_TWO};
  logic [15:0]     t_good [11] = '{16'hf448, 16'h1388, 16'h1388, 16'h0bb8, 16'h0bb8, 16'h003f,
    16'h03ff, 16'h000f, 16'h03e8, 16'hfc18, 16'h03e8};
  logic [15:0]     t_bad  [11] = '{16'hf447, 16'h1389, 16'h1389, 16'h0bb9, 16'h0bb9, 16'h0040,
    16'h0400, 16'h0010, 16'h03e9, 16'hfc17, 16'h03e9};
  logic [2:0]      s_in   [6]  = '{3'b001, 3'b010, 3'b100, 3'b000, 3'b101, 3'b011};
  logic [15:0]     s_exp  [6]  = '{STATE_FWD, STATE_REV, STATE_FAULT, STATE_STOP, STATE_FAULT, STATE_FWD};

  // Free-running clock
  always #5 clk_i = ~clk_i;

  dcr_comm_regs u_dcr_comm_regs (
    .clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid), .req_i(req), .rsp_valid_o(rsp_valid),
    .rsp_o(rsp), .run_fwd_i(run_fwd_i), .run_rev_i(run_rev_i), .fault_i(fault_i),
    .torque_setting_o(out_val[0]), .fwd_freq_ceiling_o(out_val[1]), .rev_freq_ceiling_o(out_val[2]),
    .motoring_torque_ceiling_o(out_val[3]), .braking_torque_ceiling_o(out_val[4]),
    .special_cmd_o(special_cmd), .virtual_inputs_o(vin), .virtual_outputs_o(vout),
    .separated_voltage_o(out_val[8]), .analog_out_one_o(out_val[9]), .analog_out_two_o(out_val[10]),
    .state_word_o(state_word)
  );

  // Struct outputs widened so every bank entry compares by index
  assign out_val[5] = special_cmd;
  assign out_val[6] = {6'h00, vin};
  assign out_val[7] = {12'h000, vout};

  dcr_master_model u_dcr_master_model (
    .clk_i(clk_i), .rsp_valid_i(rsp_valid), .rsp_i(rsp), .req_valid_o(req_valid), .req_o(req)
  );

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // One access with its answer compared; refused writes skip the data echo
  task automatic op(input logic w, input logic [15:0] a, input logic [7:0] q, input logic [15:0] d,
                    input logic [7:0] ec, input logic [15:0] ed);
    dcr_rsp_type r;
    logic        ok;
    u_dcr_master_model.xfer(w, a, q, d, r, ok);
    check({15'h0000, ok}, 16'h0001);
    check({7'h00, r.exc, r.exc_code}, {7'h00, ec !== EXC_NONE, ec});
    if (!w || ec === EXC_NONE) check(r.rdata, ed);
  endtask : op

  task automatic report_and_stop;
    if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  // Main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 11; i++) op(1'b0, t_addr[i], 8'h01, 16'h0000, EXC_NONE, RESET_VAL);
    op(1'b0, ADDR_STATE_WORD, 8'h01, 16'h0000, EXC_NONE, STATE_STOP);
    for (int i = 0; i < 11; i++) begin
      op(1'b1, t_addr[i], 8'h01, t_good[i], EXC_NONE, t_good[i]);
      check(out_val[i], t_good[i]);
      op(1'b1, t_addr[i], 8'h01, t_bad[i], EXC_VALUE, 16'h0000);
      check(out_val[i], t_good[i]);
      op(1'b0, t_addr[i], 8'h01, 16'h0000, EXC_NONE, t_good[i]);
    end
    op(1'b1, ADDR_VIRT_IN, 8'h02, 16'h0010, EXC_NONE, 16'h0010);
    check({15'h0000, vin.fast_input_a}, 16'h0001);
    check({6'h00, vin}, 16'h0010);
    op(1'b1, ADDR_VIRT_OUT, 8'h02, 16'h0004, EXC_NONE, 16'h0004);
    check({15'h0000, vout.relay_one}, 16'h0001);
    op(1'b1, ADDR_SPECIAL_CMD, 8'h10, 16'h0014, EXC_NONE, 16'h0014);
    check({11'h000, special_cmd.dc_brake, special_cmd.pre_excite, special_cmd.torque_ctrl_off,
           special_cmd.motor_sel}, 16'h000c);
    op(1'b1, ADDR_FWD_CEIL, 8'h11, 16'h0001, EXC_VALUE, 16'h0000);
    op(1'b1, ADDR_FWD_CEIL, 8'h00, 16'h0001, EXC_VALUE, 16'h0000);
    op(1'b0, ADDR_FWD_CEIL, 8'h01, 16'h0000, EXC_NONE, 16'h1388);
    op(1'b1, ADDR_STATE_WORD, 8'h01, 16'h0001, EXC_ADDR, 16'h0000);
    op(1'b0, 16'h2010, 8'h01, 16'h0000, EXC_ADDR, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_i);
      {fault_i, run_rev_i, run_fwd_i} <= s_in[i];
      @(posedge clk_i);
      op(1'b0, ADDR_STATE_WORD, 8'h01, 16'h0000, EXC_NONE, s_exp[i]);
      check(state_word, s_exp[i]);
    end
    report_and_stop();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #20000;
    error_cnt++;
    report_and_stop();
  end
endmodule : dcr_comm_regs_tb_top
`default_nettype wire

// *** testbench/dcr_master_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module dcr_master_model
  import dcr_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rsp_valid_i,
  input  wire dcr_rsp_type  rsp_i,
  output logic              req_valid_o,
  output dcr_req_type       req_o
);
  // Idle request port at time zero
  initial begin
    req_valid_o = 1'b0;
    req_o       = '0;
  end

  // One word per call; the frame quantity goes out as the caller gives it
  // frame quantity carried
  task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] q,
                      input logic [15:0] d, output dcr_rsp_type r, output logic ok);
    @(posedge clk_i);
    req_valid_o <= 1'b1;
    req_o       <= '{write: w, addr: a, qty: q, wdata: d};
    @(posedge clk_i);
    req_valid_o <= 1'b0;
    req_o       <= ~req_o;  // Released bus shows no stale word
    #1;
    r  = rsp_i;
    ok = rsp_valid_i;
  endtask : xfer
endmodule : dcr_master_model
`default_nettype wire
